// ===== align_check_unit.sv
// Purpose: flags misaligned memory accesses
// Assumes: byte addresses, size given per access
// Notes: combinational
`timescale 1ns/1ps
module align_check_unit
    import exec_slice_pkg::*;
(
    // link to the core
    shift_align_if.align_unit bus
);

    // low address bits that must be clear for a size
    logic [31:0] size_mask;
    assign size_mask = (bus.al_size == SZ_BYTE) ? WORD_ZERO :
                       (bus.al_size == SZ_HALF) ? HALF_MASK : WORD_MASK;

    // byte always aligned, half on 2, word and multi on 4
    assign bus.al_ok = ((bus.al_addr & size_mask) == WORD_ZERO);

endmodule : align_check_unit

// ===== barrel_shift_unit.sv
// Purpose: single-cycle shift and rotate with carry out
// Assumes: shift length is the low byte of the length register
// Notes: purely combinational
`timescale 1ns/1ps
module barrel_shift_unit
    import exec_slice_pkg::*;
(
    // link to the core
    shift_align_if.shift_unit bus
);

    // picks one operand bit by a 5-bit index
    function automatic logic pick(input logic [31:0] v,
                                  input logic [4:0] i);
        pick = v[i];
    endfunction : pick

    // ********************************************************
    // length decode
    // ********************************************************
    logic [31:0] op;
    logic [7:0] n;
    logic [4:0] e;
    logic [4:0] lo_idx;
    logic [4:0] hi_idx;
    logic zero_len;
    logic big;
    logic over;
    assign op = bus.sh_operand;
    assign n = bus.sh_amount;
    assign e = n[4:0];
    assign lo_idx = e - 5'h01; // n-1, wraps to 31 at n=32
    assign hi_idx = 5'h00 - e; // 32-n, wraps to 0 at n=32
    assign zero_len = (n == AMT_NONE);
    assign big = (n >= AMT_FULL);
    assign over = (n >= AMT_OVER);

    // ********************************************************
    // per-kind results and carries
    // ********************************************************
    logic [31:0] ari_r, lgr_r, lgl_r, rot_r;
    logic [63:0] rot_w;
    logic ari_c, lgr_c, lgl_c, rot_c;
    // sign fill, saturating at 32 and beyond
    assign ari_r = big ? {WORD_W{op[WORD_W-1]}} :
                   32'($signed(op) >>> e);
    assign ari_c = big ? op[WORD_W-1] : pick(op, lo_idx);
    // zero fill right
    assign lgr_r = big ? WORD_ZERO : (op >> e);
    assign lgr_c = over ? 1'b0 : pick(op, lo_idx);
    // zero fill left
    assign lgl_r = big ? WORD_ZERO : (op << e);
    assign lgl_c = over ? 1'b0 : pick(op, hi_idx);
    // rotate uses length modulo 32; multiples of 32 give operand back
    assign rot_w = {op, op} >> e;
    assign rot_r = rot_w[31:0];
    assign rot_c = pick(op, lo_idx);

    // ********************************************************
    // selection, zero length passes through
    // ********************************************************
    logic [31:0] sel_r;
    logic sel_c;
    assign sel_r = (bus.sh_kind == SH_ARITH_R) ? ari_r :
                   (bus.sh_kind == SH_LOGIC_R) ? lgr_r :
                   (bus.sh_kind == SH_LOGIC_L) ? lgl_r : rot_r;
    assign sel_c = (bus.sh_kind == SH_ARITH_R) ? ari_c :
                   (bus.sh_kind == SH_LOGIC_R) ? lgr_c :
                   (bus.sh_kind == SH_LOGIC_L) ? lgl_c : rot_c;
    assign bus.sh_result = zero_len ? op : sel_r;
    assign bus.sh_carry_out = zero_len ? bus.sh_carry_in : sel_c;

endmodule : barrel_shift_unit

// ===== exec_slice_pkg.sv
// Purpose: shared types and constants for the shift and alignment slice
// Assumes: 32-bit datapath, four condition flags
// Notes: flag vector order is n, z, c, v from msb to lsb
package exec_slice_pkg;

    // ********************************************************
    // widths and flag positions
    // ********************************************************
    localparam int WORD_W = 32;
    localparam int AMT_W = 8;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ********************************************************
    // shift lengths, fetch offset, link mark, alignment masks
    // ********************************************************
    localparam logic [7:0] AMT_NONE = 8'h00;
    localparam logic [7:0] AMT_FULL = 8'h20;
    localparam logic [7:0] AMT_OVER = 8'h21;
    localparam logic [31:0] FETCH_OFFSET = 32'h0000_0004;
    localparam logic [31:0] LINK_MARK = 32'h0000_0001;
    localparam logic [31:0] HALF_MASK = 32'h0000_0001;
    localparam logic [31:0] WORD_MASK = 32'h0000_0003;

    // ********************************************************
    // enumerations
    // ********************************************************
    typedef enum logic [1:0] {
        SH_ARITH_R = 2'h0,
        SH_LOGIC_R = 2'h1,
        SH_LOGIC_L = 2'h2,
        SH_ROTATE_R = 2'h3
    } shift_kind_type;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2,
        SZ_MULTI = 2'h3
    } size_type;

    typedef enum logic [2:0] {
        OP_IDLE = 3'h0,
        OP_SHIFT = 3'h1,
        OP_FLAGS = 3'h2,
        OP_MEM = 3'h3,
        OP_BRANCH = 3'h4,
        OP_LINK = 3'h5
    } op_kind_type;

    typedef enum logic [3:0] {
        COND_EQ = 4'h0, COND_NE = 4'h1, COND_CS = 4'h2, COND_CC = 4'h3,
        COND_MI = 4'h4, COND_PL = 4'h5, COND_VS = 4'h6, COND_VC = 4'h7,
        COND_HI = 4'h8, COND_LS = 4'h9, COND_GE = 4'ha, COND_LT = 4'hb,
        COND_GT = 4'hc, COND_LE = 4'hd, COND_AL = 4'he
    } cond_type;

endpackage : exec_slice_pkg

// ===== shift_align_core.sv
// Purpose: shift, alignment check, fetch offset, link and flag keeping
// Assumes: one request per cycle, answers one cycle later
// Notes: flags update only on flag-setting requests
//
// How it works
// - zero length: operand through, carry kept
// - arith right fills top with sign
// - arith right carry is bit n-1
// - arith right 32+: all sign, carry bit31
// - logical right fills top with zeros
// - logical right carry is bit n-1
// - logical shifts of 32+ give zero
// - logical shifts of 33+ clear carry
// - logical left fills bottom with zeros
// - logical left carry bit 32-n
// - rotate wraps low bits, carry bit n-1
// - rotate 32: operand back, carry bit31
// - rotate over 32 acts as n-32
// - word/half need alignment, bytes always fine
// - misaligned access faults, is not performed
// - counter operand is instruction address plus four
// - link value gets bit 0 set
// - unwritten flags keep prior value
// - branch sees last written flags
// - equal when zero set, else not
`timescale 1ns/1ps
module shift_align_core
    import exec_slice_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // request
    input wire logic op_valid,
    input wire op_kind_type op_kind,
    input wire shift_kind_type shift_kind,
    input wire logic set_flags,
    input wire logic [31:0] operand,
    input wire logic [7:0] amount,
    input wire logic [3:0] ext_flags,
    input wire logic [3:0] ext_flag_mask,
    input wire logic [31:0] mem_addr,
    input wire size_type mem_size,
    input wire logic [31:0] instr_addr,
    input wire cond_type cond,
    // shift answer
    output logic [31:0] result,
    output logic result_valid,
    output logic [3:0] app_status_flags,
    // memory answer
    output logic mem_go,
    output logic severe_fault_exception,
    // counter, link and branch answers
    output logic [31:0] program_counter,
    output logic [31:0] link_register,
    output logic link_write,
    output logic branch_taken,
    output logic branch_done
);

    // decides a branch condition from the flags
    function automatic logic cond_true(input cond_type c,
                                       input logic [3:0] f);
        logic n, z, cy, v;
        n = f[FLAG_N];
        z = f[FLAG_Z];
        cy = f[FLAG_C];
        v = f[FLAG_V];
        case (c)
            COND_EQ: cond_true = z;
            COND_NE: cond_true = !z;
            COND_CS: cond_true = cy;
            COND_CC: cond_true = !cy;
            COND_MI: cond_true = n;
            COND_PL: cond_true = !n;
            COND_VS: cond_true = v;
            COND_VC: cond_true = !v;
            COND_HI: cond_true = cy && !z;
            COND_LS: cond_true = !cy || z;
            COND_GE: cond_true = (n == v);
            COND_LT: cond_true = (n != v);
            COND_GT: cond_true = !z && (n == v);
            COND_LE: cond_true = z || (n != v);
            default: cond_true = 1'b1;
        endcase
    endfunction : cond_true

    // ********************************************************
    // units
    // ********************************************************
    shift_align_if link_bus ();

    barrel_shift_unit u_barrel_shift_unit (
        .bus (link_bus.shift_unit)
    );

    align_check_unit u_align_check_unit (
        .bus (link_bus.align_unit)
    );

    // ********************************************************
    // registers
    // ********************************************************
    logic [3:0] flags_q, flags_d;
    logic [31:0] result_q, result_d;
    logic result_valid_q;
    logic [31:0] prog_q, prog_d;
    logic [31:0] link_q, link_d;
    logic link_write_q;
    logic mem_go_q;
    logic fault_q;
    logic taken_q;
    logic br_done_q;

    // ********************************************************
    // request decode
    // ********************************************************
    logic do_shift, do_flags, do_mem, do_branch, do_link;
    assign do_shift = op_valid && (op_kind == OP_SHIFT);
    assign do_flags = op_valid && (op_kind == OP_FLAGS);
    assign do_mem = op_valid && (op_kind == OP_MEM);
    assign do_branch = op_valid && (op_kind == OP_BRANCH);
    assign do_link = op_valid && (op_kind == OP_LINK);

    // drive the shared bus toward the units
    assign link_bus.sh_kind = shift_kind;
    assign link_bus.sh_operand = operand;
    assign link_bus.sh_amount = amount;
    assign link_bus.sh_carry_in = flags_q[FLAG_C];
    assign link_bus.al_addr = mem_addr;
    assign link_bus.al_size = mem_size;

    // ********************************************************
    // next-state values
    // ********************************************************
    // flags from the shift: n, z, carry, v kept
    logic [3:0] shift_flags;
    logic [3:0] ext_merge;
    assign shift_flags = {link_bus.sh_result[WORD_W-1],
                          link_bus.sh_result == WORD_ZERO,
                          link_bus.sh_carry_out,
                          flags_q[FLAG_V]};
    assign ext_merge = (flags_q & ~ext_flag_mask) |
                       (ext_flags & ext_flag_mask);
    assign flags_d = (do_shift && set_flags) ? shift_flags :
                     do_flags ? ext_merge : flags_q;

    // result held until the next shift
    assign result_d = do_shift ? link_bus.sh_result : result_q;
    // counter operand and link value
    assign prog_d = op_valid ? (instr_addr + FETCH_OFFSET) : prog_q;
    assign link_d = do_link ? ((instr_addr + FETCH_OFFSET) | LINK_MARK) :
                    link_q;

    // ********************************************************
    // state update
    // ********************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_q <= FLAGS_RST;
            result_q <= WORD_ZERO;
            prog_q <= WORD_ZERO;
            link_q <= WORD_ZERO;
        end else begin
            flags_q <= flags_d;
            result_q <= result_d;
            prog_q <= prog_d;
            link_q <= link_d;
        end
    end

    // one-cycle answer strobes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_valid_q <= 1'b0;
            link_write_q <= 1'b0;
            mem_go_q <= 1'b0;
            fault_q <= 1'b0;
            taken_q <= 1'b0;
            br_done_q <= 1'b0;
        end else begin
            result_valid_q <= do_shift;
            link_write_q <= do_link;
            mem_go_q <= do_mem && link_bus.al_ok;
            fault_q <= do_mem && !link_bus.al_ok;
            taken_q <= do_branch && cond_true(cond, flags_q);
            br_done_q <= do_branch;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign result = result_q;
    assign result_valid = result_valid_q;
    assign app_status_flags = flags_q;
    assign mem_go = mem_go_q;
    assign severe_fault_exception = fault_q;
    assign program_counter = prog_q;
    assign link_register = link_q;
    assign link_write = link_write_q;
    assign branch_taken = taken_q;
    assign branch_done = br_done_q;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // expected carry bit n-1 for lengths 1..31
    logic exp_lo_bit;
    logic [4:0] exp_lo_idx;
    assign exp_lo_idx = amount[4:0] - 5'h01;
    assign exp_lo_bit = operand[exp_lo_idx];

    AST_ZERO_LEN: assert property (
        do_shift && amount == AMT_NONE |=>
        result_q == $past(operand) &&
        flags_q[FLAG_C] == $past(flags_q[FLAG_C]))
        else $error("zero length shift altered data or carry");

    AST_ARI_BIG: assert property (
        do_shift && shift_kind == SH_ARITH_R && set_flags &&
        amount >= AMT_FULL |=>
        result_q == {WORD_W{$past(operand[WORD_W-1])}} &&
        flags_q[FLAG_C] == $past(operand[WORD_W-1]))
        else $error("long arithmetic shift not sign filled");

    AST_ARI_CARRY: assert property (
        do_shift && shift_kind == SH_ARITH_R && set_flags &&
        amount != AMT_NONE && amount < AMT_FULL |=>
        flags_q[FLAG_C] == $past(exp_lo_bit))
        else $error("arithmetic shift carry wrong");

    AST_LGR_CARRY: assert property (
        do_shift && shift_kind == SH_LOGIC_R && set_flags &&
        amount != AMT_NONE && amount < AMT_OVER |=>
        flags_q[FLAG_C] == $past(exp_lo_bit))
        else $error("logical right carry wrong");

    AST_LOG_ZERO: assert property (
        do_shift && amount >= AMT_FULL &&
        (shift_kind == SH_LOGIC_R || shift_kind == SH_LOGIC_L) |=>
        result_q == WORD_ZERO)
        else $error("long logical shift not zero");

    AST_LOG_CLEAR: assert property (
        do_shift && set_flags && amount >= AMT_OVER &&
        (shift_kind == SH_LOGIC_R || shift_kind == SH_LOGIC_L) |=>
        !flags_q[FLAG_C])
        else $error("carry not cleared past 32");

    AST_LGL_TOP: assert property (
        do_shift && shift_kind == SH_LOGIC_L && set_flags &&
        amount == AMT_FULL |=> flags_q[FLAG_C] == $past(operand[0]))
        else $error("left shift by 32 carry wrong");

    AST_ROT_FULL: assert property (
        do_shift && shift_kind == SH_ROTATE_R && set_flags &&
        amount == AMT_FULL |=> result_q == $past(operand) &&
        flags_q[FLAG_C] == $past(operand[WORD_W-1]))
        else $error("rotate by 32 wrong");

    AST_FAULT: assert property (
        do_mem && (mem_addr[0] && mem_size != SZ_BYTE) |=>
        severe_fault_exception && !mem_go)
        else $error("misaligned access not faulted");

    AST_BYTE_OK: assert property (
        do_mem && mem_size == SZ_BYTE |=> mem_go && !fault_q)
        else $error("byte access refused");

    AST_PROG_OFS: assert property (
        op_valid |=> program_counter == $past(instr_addr) + FETCH_OFFSET)
        else $error("counter operand offset wrong");

    AST_LINK_BIT: assert property (
        do_link |=> link_write ##0 link_register[0])
        else $error("link value bit 0 clear");

    AST_FLAG_HOLD: assert property (
        !(do_shift && set_flags) && !do_flags |=> $stable(flags_q))
        else $error("flags changed without a writer");

    AST_EQ_NE: assert property (
        do_branch && (cond == COND_EQ || cond == COND_NE) |=>
        branch_taken == ($past(cond == COND_EQ) ==
                         $past(flags_q[FLAG_Z])))
        else $error("equal condition misread");

    AST_BR_LAST: assert property (
        do_flags && ext_flag_mask[FLAG_Z] && ext_flags[FLAG_Z]
        ##1 (!do_flags && !(do_shift && set_flags))
        ##1 do_branch && cond == COND_EQ |=> branch_taken)
        else $error("branch missed last written flags");

    AST_ROT_WRAP: assert property (
        do_shift && shift_kind == SH_ROTATE_R && set_flags &&
        amount > AMT_FULL && amount[4:0] != AMT_NONE[4:0] |=>
        flags_q[FLAG_C] == $past(exp_lo_bit))
        else $error("rotate past 32 carry differs from n-32");

    AST_ONE_CYCLE: assert property (
        do_shift |=> result_valid)
        else $error("shift answer not ready next cycle");

    COV_ROT_WRAP: cover property (
        do_shift && shift_kind == SH_ROTATE_R && amount > AMT_FULL);
    COV_LONG_ARI: cover property (
        do_shift && shift_kind == SH_ARITH_R && amount > AMT_FULL);
    COV_FAULT: cover property (do_mem && !link_bus.al_ok);
    COV_BRANCH: cover property (
        do_shift && set_flags ##[1:4] do_branch ##1 branch_taken);

endmodule : shift_align_core

// ===== shift_align_if.sv
// Purpose: carries shifter and alignment signals inside the slice
// Assumes: all signals combinational within one cycle
// Notes: core drives requests, the two units answer
`timescale 1ns/1ps
interface shift_align_if;
    import exec_slice_pkg::*;

    // shifter request and answer
    shift_kind_type sh_kind;
    logic [31:0] sh_operand;
    logic [7:0] sh_amount;
    logic sh_carry_in;
    logic [31:0] sh_result;
    logic sh_carry_out;

    // alignment request and answer
    logic [31:0] al_addr;
    size_type al_size;
    logic al_ok;

    modport shift_unit (
        input sh_kind, sh_operand, sh_amount, sh_carry_in,
        output sh_result, sh_carry_out
    );
    modport align_unit (
        input al_addr, al_size,
        output al_ok
    );
    modport core (
        output sh_kind, sh_operand, sh_amount, sh_carry_in,
        output al_addr, al_size,
        input sh_result, sh_carry_out, al_ok
    );
endinterface : shift_align_if

// ===== test_shift_align_core.sv
// Purpose: self-checking bench for the shift and alignment slice
// Assumes: inputs change on the falling edge, answers one cycle later
// Notes: shift cases sit in a row table, the rest are hand-written
`timescale 1ns/1ps
module test_shift_align_core;
    import exec_slice_pkg::*;

    // ********************************************************
    // design hookup
    // ********************************************************
    logic mclk, sys_rst, op_valid, set_flags;
    op_kind_type op_kind;
    shift_kind_type shift_kind;
    logic [31:0] operand, mem_addr, instr_addr;
    logic [7:0] amount;
    logic [3:0] ext_flags, ext_flag_mask;
    size_type mem_size;
    cond_type cond;
    logic [31:0] result, program_counter, link_register;
    logic [3:0] app_status_flags;
    logic result_valid, mem_go, severe_fault_exception;
    logic link_write, branch_taken, branch_done;
    int n_errors = 0;
    int compares = 0;

    shift_align_core u_shift_align_core (
        .mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_kind(op_kind), .shift_kind(shift_kind),
        .set_flags(set_flags), .operand(operand), .amount(amount),
        .ext_flags(ext_flags), .ext_flag_mask(ext_flag_mask),
        .mem_addr(mem_addr), .mem_size(mem_size),
        .instr_addr(instr_addr), .cond(cond), .result(result),
        .result_valid(result_valid),
        .app_status_flags(app_status_flags), .mem_go(mem_go),
        .severe_fault_exception(severe_fault_exception),
        .program_counter(program_counter),
        .link_register(link_register), .link_write(link_write),
        .branch_taken(branch_taken), .branch_done(branch_done)
    );

    // ********************************************************
    // shift table: kind 0 arith right, 1 logical right,
    // 2 logical left, 3 rotate right; cin is the carry before
    // ********************************************************
    typedef struct {
        logic [1:0] k;
        logic [31:0] op;
        logic [7:0] amt;
        logic cin;
        logic [31:0] res;
        logic cout;
    } shift_row_type;

    shift_row_type rows [14] = '{
        '{2'h0, 32'h8000_0018, 8'h04, 1'b0, 32'hf800_0001, 1'b1},
        '{2'h0, 32'h8000_0000, 8'h20, 1'b0, 32'hffff_ffff, 1'b1},
        '{2'h0, 32'h8000_0000, 8'hc8, 1'b0, 32'hffff_ffff, 1'b1},
        '{2'h0, 32'h1234_5678, 8'h00, 1'b1, 32'h1234_5678, 1'b1},
        '{2'h1, 32'hf000_0001, 8'h01, 1'b0, 32'h7800_0000, 1'b1},
        '{2'h1, 32'h8000_0000, 8'h20, 1'b0, 32'h0000_0000, 1'b1},
        '{2'h1, 32'hffff_ffff, 8'h21, 1'b1, 32'h0000_0000, 1'b0},
        '{2'h2, 32'h8000_0003, 8'h01, 1'b0, 32'h0000_0006, 1'b1},
        '{2'h2, 32'h0000_0001, 8'h20, 1'b0, 32'h0000_0000, 1'b1},
        '{2'h2, 32'hffff_ffff, 8'h28, 1'b1, 32'h0000_0000, 1'b0},
        '{2'h2, 32'h0000_0005, 8'h00, 1'b1, 32'h0000_0005, 1'b1},
        '{2'h3, 32'h0000_001b, 8'h04, 1'b0, 32'hb000_0001, 1'b1},
        '{2'h3, 32'h8000_0001, 8'h20, 1'b0, 32'h8000_0001, 1'b1},
        '{2'h3, 32'h0000_001b, 8'h24, 1'b0, 32'hb000_0001, 1'b1}
    };

    // ********************************************************
    // clock and watchdog
    // ********************************************************
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        #(4 * 5000);
        n_errors++;
        $display("mismatch t=%0t watchdog expired", $time);
        print_verdict();
    end

    // ********************************************************
    // compare and drive tasks
    // ********************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t flags got %b exp %b", $time, got, exp);
        end
    endtask : chk_flags

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    // request taken at the next rising edge, seen at the falling one
    task automatic go(input op_kind_type k);
        op_valid = 1'b1;
        op_kind = k;
        @(negedge mclk);
    endtask : go

    task automatic idle();
        op_valid = 1'b0;
        op_kind = OP_IDLE;
        @(negedge mclk);
    endtask : idle

    // condition meaning worked out from the flags n,z,c,v
    function automatic logic cond_true(input logic [3:0] f, input int c);
        logic n, z, cy, v;
        {n, z, cy, v} = f;
        case (c)
            0: return z;
            1: return !z;
            2: return cy;
            3: return !cy;
            4: return n;
            5: return !n;
            6: return v;
            7: return !v;
            8: return cy && !z;
            9: return !cy || z;
            10: return n == v;
            11: return n != v;
            12: return !z && (n == v);
            13: return z || (n != v);
            default: return 1'b1;
        endcase
    endfunction : cond_true

    task automatic print_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        logic ok;
        logic [31:0] last;
        sys_rst = 1'b1;
        op_valid = 1'b0;
        op_kind = OP_IDLE;
        shift_kind = shift_kind_type'(2'h0);
        set_flags = 1'b0;
        operand = 32'h0000_0000;
        amount = 8'h00;
        ext_flags = 4'h0;
        ext_flag_mask = 4'h0;
        mem_addr = 32'h0000_0000;
        mem_size = size_type'(2'h0);
        instr_addr = 32'h0000_0000;
        cond = cond_type'(4'h0);
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        chk_word(result, 32'h0000_0000);
        chk_flags(app_status_flags, 4'h0);
        chk_word(program_counter, 32'h0000_0000);
        chk_bit(result_valid, 1'b0);
        $display("test reset done");

        // table of shifts, carry preset through a masked flag write
        foreach (rows[i]) begin
            ext_flags = {2'b00, rows[i].cin, 1'b1};
            ext_flag_mask = 4'b0011;
            go(OP_FLAGS);
            shift_kind = shift_kind_type'(rows[i].k);
            operand = rows[i].op;
            amount = rows[i].amt;
            set_flags = 1'b1;
            go(OP_SHIFT);
            chk_word(result, rows[i].res);
            chk_flags(app_status_flags, {rows[i].res[31],
                rows[i].res == 32'h0, rows[i].cout, 1'b1});
            chk_bit(result_valid, 1'b1);
        end
        last = result;
        idle();
        chk_bit(result_valid, 1'b0);
        chk_word(result, last);
        $display("test shift table done");

        // flags, a non-flag shift in between, then every condition
        for (int f = 0; f < 16; f++) begin
            ext_flags = f[3:0];
            ext_flag_mask = 4'hf;
            go(OP_FLAGS);
            set_flags = 1'b0;
            operand = 32'h0000_0001;
            amount = 8'h01;
            go(OP_SHIFT);
            chk_flags(app_status_flags, f[3:0]);
            for (int c = 0; c < 16; c++) begin
                cond = cond_type'(c[3:0]);
                instr_addr = 32'h0000_1000 + 32'(c * 2);
                go(OP_BRANCH);
                chk_bit(branch_taken, cond_true(f[3:0], c));
                chk_bit(branch_done, 1'b1);
                chk_word(program_counter, instr_addr + 32'h0000_0004);
            end
        end
        ext_flags = 4'h0;
        ext_flag_mask = 4'b0100;
        go(OP_FLAGS);
        chk_flags(app_status_flags, 4'b1011);
        $display("test conditions done");

        // every size against every low address pattern
        for (int s = 0; s < 4; s++) begin
            for (int a = 0; a < 4; a++) begin
                mem_addr = 32'h0000_2000 | 32'(a);
                mem_size = size_type'(s[1:0]);
                go(OP_MEM);
                ok = (s == 0) || (s == 1 && a[0] == 1'b0) || (a == 0);
                chk_bit(mem_go, ok);
                chk_bit(severe_fault_exception, !ok);
            end
        end
        idle();
        chk_bit(severe_fault_exception, 1'b0);
        $display("test alignment done");

        // link value and counter offset, then a pulse check
        instr_addr = 32'h0000_0100;
        go(OP_LINK);
        chk_word(link_register, 32'h0000_0105);
        chk_word(program_counter, 32'h0000_0104);
        chk_bit(link_write, 1'b1);
        idle();
        chk_bit(link_write, 1'b0);
        chk_word(link_register, 32'h0000_0105);
        $display("test link done");

        // reset again in mid-run clears flags and result
        sys_rst = 1'b1;
        @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        chk_flags(app_status_flags, 4'h0);
        chk_word(result, 32'h0000_0000);
        $display("test second reset done");
        print_verdict();
    end
endmodule : test_shift_align_core
